// File: common/omd_pkg.sv
// ---------------------------------------------------------------------------
// shared constants and types of the on-chip memory map decoder
// ---------------------------------------------------------------------------
package omd_pkg;

  // requester slots, index order is also the fixed priority (0 = highest)
  localparam int NUM_REQ     = 5;
  localparam int REQ_PROG    = 0;  // program fetch bus, read only
  localparam int REQ_DREAD   = 1;  // data read bus
  localparam int REQ_DWRITE  = 2;  // data write bus
  localparam int REQ_DMA     = 3;  // dma controller port, 32-bit
  localparam int REQ_USB_LCD = 4;  // usb and lcd dma bus

  // cpu byte address map
  localparam logic [31:0] DPR_CPU_LAST = 32'h0000_ffff;
  localparam logic [31:0] MMR_BYTES    = 32'h0000_00c0;  // 192 bytes
  localparam logic [31:0] SPR_CPU_BASE = 32'h0001_0000;
  localparam logic [31:0] SPR_CPU_LAST = 32'h0004_ffff;
  localparam logic [31:0] ROM_CPU_BASE = 32'h00fe_0000;
  localparam logic [31:0] ROM_CPU_LAST = 32'h00ff_ffff;

  // dma side byte address map
  localparam logic [31:0] DPR_DMA_BASE = 32'h0001_0000;
  localparam logic [31:0] DPR_DMA_LAST = 32'h0001_ffff;
  localparam logic [31:0] SPR_DMA_BASE = 32'h0009_0000;
  localparam logic [31:0] SPR_DMA_LAST = 32'h000c_ffff;

  // field positions inside a byte address
  localparam int WORD_LSB    = 1;   // 16-bit words
  localparam int RAM_WORD_W  = 12;  // 4K words per ram block
  localparam int ROM_WORD_W  = 14;  // 16K words per rom block
  localparam int RAM_BLK_LSB = 13;  // 8K bytes per ram block
  localparam int ROM_BLK_LSB = 15;  // 32K bytes per rom block
  localparam int ROM_BLK_W   = 2;   // four rom blocks
  localparam int BLK_W       = 5;   // up to 32 blocks
  localparam int CNT_W       = 3;

  // accesses each block accepts per cycle
  localparam logic [2:0] DPR_PORTS  = 3'h2;
  localparam logic [2:0] SPR_PORTS  = 3'h1;
  localparam logic [2:0] ROM_PORTS  = 3'h1;
  localparam logic [2:0] FREE_PORTS = 3'h7;

  typedef enum logic [2:0] {
    RGN_NONE, RGN_MMR, RGN_DPR, RGN_SPR, RGN_ROM
  } omd_region_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        wide;
    logic [31:0] addr;
    logic [31:0] wdata;
  } omd_req_t;

  typedef struct packed {
    omd_region_t        region;
    logic [BLK_W-1:0]   block;
    logic [ROM_WORD_W-1:0] word;
  } omd_tgt_t;

  typedef struct packed {
    logic                  valid;
    omd_region_t           region;
    logic [BLK_W-1:0]      block;
    logic [ROM_WORD_W-1:0] word;
    logic                  write;
    logic                  wide;
    logic [31:0]           wdata;
  } omd_cmd_t;

endpackage : omd_pkg

// File: rtl/omd_decoder.sv
// Summary of operation
// - cpu bytes 000000h to 00ffffh decode to the dual port ram region.
// - dual port region is eight blocks of 4K words, chosen by upper bits.
// - each dual port block takes two accesses in one cycle, any mix.
// - dual port region is open to program, data and dma buses.
// - dma sees dual port region at cpu byte address plus 0x10000.
// - lowest 192 bytes of block zero go to cpu mapped registers.
// - rom is four 16K-word blocks at cpu bytes fe0000h to ffffffh.
// - with rom unmap bit clear the top range goes to the rom.
// - with rom unmap bit set the top range is unmapped.
// - hardware reset clears the rom unmap bit.
// - software reset instruction leaves the rom unmap bit alone.
// - rom read only from program and data buses, one word per block per cycle.
// - cpu bytes 010000h to 04ffffh map to 32 single port blocks.
// - each single port block does at most one access per cycle.
// - single port region is open to program, data and dma buses.
// - single port region also open to the usb and lcd dma bus.
// - dma and usb see single port region from 0x90000, 0x2000 per block.
// - each dma port completes one 32-bit transfer per cycle.
`timescale 1ns/100ps

module omd_decoder (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  // requests from cpu buses and dma ports, one slot each
  input  wire omd_pkg::omd_req_t    req       [omd_pkg::NUM_REQ],
  // rom unmap bit control from the cpu status word three logic
  input  wire logic                 romUnmapSet,
  input  wire logic                 romUnmapClear,
  // commands toward the memory arrays and register file
  output omd_pkg::omd_cmd_t         cmd       [omd_pkg::NUM_REQ],
  // per slot flow control and error
  output logic                      stall     [omd_pkg::NUM_REQ],
  output logic                      fault     [omd_pkg::NUM_REQ],
  // current rom unmap bit
  output logic                      romUnmap
);
  import omd_pkg::*;

  // ---------------------------------------------------------------------------
  // decode functions
  // ---------------------------------------------------------------------------

  // inclusive byte window test, used by the single port, rom and dma side region checks
  function automatic logic inWindow(
    input logic [31:0] a,
    input logic [31:0] lo,
    input logic [31:0] hi
  );
    inWindow = (a >= lo) && (a <= hi);
  endfunction : inWindow

  // ram target from an offset into a ram region, 8K bytes per block
  function automatic omd_tgt_t ramTarget(
    input omd_region_t rgn,
    input logic [31:0] off
  );
    ramTarget        = '{region: RGN_NONE, block: '0, word: '0};
    ramTarget.region = rgn;
    ramTarget.block  = off[RAM_BLK_LSB +: BLK_W];
    ramTarget.word   = {2'h0, off[WORD_LSB +: RAM_WORD_W]};
  endfunction : ramTarget

  // dual port offset to target, register file claims the bottom bytes
  function automatic omd_tgt_t dprTarget(input logic [31:0] off);
    omd_region_t rgn;
    rgn       = (off < MMR_BYTES) ? RGN_MMR : RGN_DPR;
    dprTarget = ramTarget(rgn, off);
  endfunction : dprTarget

  // rom target, 32K bytes per block and 16-bit words
  function automatic omd_tgt_t romTarget(input logic [31:0] a);
    romTarget        = '{region: RGN_NONE, block: '0, word: '0};
    romTarget.region = RGN_ROM;
    romTarget.block  = {3'h0, a[ROM_BLK_LSB +: ROM_BLK_W]};
    romTarget.word   = a[WORD_LSB +: ROM_WORD_W];
  endfunction : romTarget

  // cpu buses: dual port, single port, then rom when mapped
  function automatic omd_tgt_t cpuTarget(
    input omd_req_t r,
    input int       idx,
    input logic     unmap
  );
    omd_tgt_t t;
    t = '{region: RGN_NONE, block: '0, word: '0};
    if (r.addr <= DPR_CPU_LAST) begin
      t = dprTarget(r.addr);
    end else if (inWindow(r.addr, SPR_CPU_BASE, SPR_CPU_LAST)) begin
      t = ramTarget(RGN_SPR, r.addr - SPR_CPU_BASE);
    end else if (inWindow(r.addr, ROM_CPU_BASE, ROM_CPU_LAST) &&
                 !unmap && !r.write && idx != REQ_DWRITE) begin
      // rom only for reads on cpu buses
      t = romTarget(r.addr);
    end
    // anything else stays unmapped and ends as a fault pulse
    return t;
  endfunction : cpuTarget

  // dma side: controller port reaches both rams, usb and lcd one only
  function automatic omd_tgt_t dmaTarget(
    input omd_req_t r,
    input int       idx
  );
    omd_tgt_t t;
    t = '{region: RGN_NONE, block: '0, word: '0};
    if (idx == REQ_DMA &&
        inWindow(r.addr, DPR_DMA_BASE, DPR_DMA_LAST)) begin
      t = dprTarget(r.addr - DPR_DMA_BASE);
    end else if (inWindow(r.addr, SPR_DMA_BASE, SPR_DMA_LAST)) begin
      t = ramTarget(RGN_SPR, r.addr - SPR_DMA_BASE);
    end
    // the dma side never reaches the rom, it has no path there
    return t;
  endfunction : dmaTarget

  // byte address of a slot to region, block and word
  function automatic omd_tgt_t decodeAddr(
    input omd_req_t r,
    input int       idx,
    input logic     unmap
  );
    if (idx >= REQ_DMA) begin
      decodeAddr = dmaTarget(r, idx);
    end else begin
      decodeAddr = cpuTarget(r, idx, unmap);
    end
  endfunction : decodeAddr

  // accesses that one block of a region accepts per cycle
  function automatic logic [CNT_W-1:0] portsOf(input omd_region_t rgn);
    case (rgn)
      RGN_DPR: portsOf = DPR_PORTS;
      RGN_SPR: portsOf = SPR_PORTS;
      RGN_ROM: portsOf = ROM_PORTS;
      default: portsOf = FREE_PORTS;
    endcase
  endfunction : portsOf

  // two targets hit the same physical block
  function automatic logic sameBlock(input omd_tgt_t a, input omd_tgt_t b);
    sameBlock = (a.region == b.region) && (a.block == b.block);
  endfunction : sameBlock

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------

  omd_req_t  hold   [NUM_REQ];  // request parked after losing arbitration
  omd_req_t  cur    [NUM_REQ];  // request competing this cycle
  omd_tgt_t  tgt    [NUM_REQ];
  logic      grant  [NUM_REQ];
  omd_req_t  next_hold [NUM_REQ];

  // ---------------------------------------------------------------------------
  // rom unmap bit
  // ---------------------------------------------------------------------------

  // hardware reset, or romUnmapClear without romUnmapSet, clears it, no other reset reaches this flop
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      romUnmap <= 1'b0;
    end else if (romUnmapSet) begin
      romUnmap <= 1'b1;
    end else if (romUnmapClear) begin
      romUnmap <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // select, decode and arbitrate
  // ---------------------------------------------------------------------------

  // a parked request replaces the port input until it is granted
  always_comb begin
    for (int i = 0; i < NUM_REQ; i++) begin
      cur[i] = hold[i].valid ? hold[i] : req[i];
      if (i == REQ_PROG) begin
        cur[i].write = 1'b0; // program bus only fetches
      end
      tgt[i] = decodeAddr(cur[i], i, romUnmap);
    end
  end

  // why arbitration looks like this:
  // - the grant count runs in slot order, so slot 0 always wins first
  // - a dual port block lets two slots through, single port and rom one
  // - register file and unmapped hits never block one another
  // - a loser is parked and its source sees stall, so the port input
  //   is ignored until the parked copy wins; no request is lost or doubled

  // lower index wins a block, count earlier grants on the same block
  always_comb begin
    logic [CNT_W-1:0] used;
    used = '0;
    for (int i = 0; i < NUM_REQ; i++) begin
      used = '0;
      for (int j = 0; j < i; j++) begin
        if (grant[j] && sameBlock(tgt[j], tgt[i])) begin
          used = used + 3'h1;
        end
      end
      grant[i] = cur[i].valid && (used < portsOf(tgt[i].region));
    end
  end

  // losers are parked, winners and idle slots clear the park
  always_comb begin
    for (int i = 0; i < NUM_REQ; i++) begin
      next_hold[i] = '0;
      if (cur[i].valid && !grant[i]) begin
        next_hold[i] = cur[i];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // parked requests and stall
  // ---------------------------------------------------------------------------

  // stall mirrors the park, so it falls on the edge the parked copy wins
  generate
    for (genvar g = 0; g < NUM_REQ; g++) begin : gSlot

      // parked request
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          hold[g] <= '0;
        end else begin
          hold[g] <= next_hold[g];
        end
      end

      // stall tells the source that its request is parked
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          stall[g] <= 1'b0;
        end else begin
          stall[g] <= next_hold[g].valid;
        end
      end

    end
  endgenerate

  // ---------------------------------------------------------------------------
  // command and fault outputs
  // ---------------------------------------------------------------------------

  // both outputs stand for exactly one cycle after the winning edge
  generate
    for (genvar g = 0; g < NUM_REQ; g++) begin : gOut

      // granted access goes out one cycle later, one per slot per cycle
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          cmd[g] <= '0;
        end else begin
          cmd[g].valid  <= grant[g] && (tgt[g].region != RGN_NONE);
          cmd[g].region <= tgt[g].region;
          cmd[g].block  <= tgt[g].block;
          cmd[g].word   <= tgt[g].word;
          cmd[g].write  <= cur[g].write;
          cmd[g].wide   <= cur[g].wide;
          cmd[g].wdata  <= cur[g].wdata;
        end
      end

      // unmapped address, rom write or rom while unmapped
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          fault[g] <= 1'b0;
        end else begin
          fault[g] <= grant[g] && (tgt[g].region == RGN_NONE);
        end
      end

    end
  endgenerate

endmodule : omd_decoder

// File: sim/omd_decoder_monitor.sv
`timescale 1ns/100ps
module omd_decoder_monitor (
  // clock and reset
  input wire logic              core_clk,
  input wire logic              reset_n,
  // watched ports
  input wire omd_pkg::omd_req_t req [omd_pkg::NUM_REQ],
  input wire logic              romUnmapSet,
  input wire logic              romUnmapClear,
  input wire omd_pkg::omd_cmd_t cmd [omd_pkg::NUM_REQ],
  input wire logic              stall [omd_pkg::NUM_REQ],
  input wire logic              fault [omd_pkg::NUM_REQ],
  input wire logic              romUnmap
);
  import omd_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic [4:0] busy;
  logic [4:0] fresh;
  // per slot activity
  always_comb begin
    for (int i = 0; i < NUM_REQ; i++) begin
      busy[i]  = req[i].valid || stall[i];
      fresh[i] = req[i].valid && !stall[i];
    end
  end
  sequence s_loss;
    cmd[1].valid && !cmd[4].valid && stall[4];
  endsequence
  property p_mmr;
    fresh[1] && req[1].addr < MMR_BYTES |=> cmd[1].region == RGN_MMR;
  endproperty
  a_mmr: assert property (p_mmr) else $error("mmr miss");
  property p_dpr_cpu;
    fresh[1] && req[1].addr inside {[MMR_BYTES:DPR_CPU_LAST]} |=>
      cmd[1].valid && cmd[1].block == {2'h0, $past(req[1].addr[15:13])};
  endproperty
  a_dpr_cpu: assert property (p_dpr_cpu) else $error("dpr cpu");
  property p_dpr_dma;
    fresh[3] && busy[2:0] == 3'h0 && req[3].addr inside
      {[DPR_DMA_BASE + MMR_BYTES:DPR_DMA_LAST]} |=> cmd[3].valid &&
      cmd[3].region == RGN_DPR && cmd[3].wide == $past(req[3].wide);
  endproperty
  a_dpr_dma: assert property (p_dpr_dma) else $error("dpr dma");
  property p_spr_usb;
    fresh[4] && busy[3:0] == 4'h0 && req[4].addr inside
      {[SPR_DMA_BASE:SPR_DMA_LAST]} |=> cmd[4].region == RGN_SPR &&
      cmd[4].block == $past(req[4].addr[17:13]) - 5'h08;
  endproperty
  a_spr_usb: assert property (p_spr_usb) else $error("spr usb");
  property p_rom_on;
    fresh[0] && !romUnmap && req[0].addr >= ROM_CPU_BASE &&
      req[0].addr <= ROM_CPU_LAST |=>
      cmd[0].region == RGN_ROM && cmd[0].block == $past(req[0].addr[16:15]);
  endproperty
  a_rom_on: assert property (p_rom_on) else $error("rom map");
  property p_rom_off;
    fresh[0] && romUnmap && req[0].addr >= ROM_CPU_BASE &&
      req[0].addr <= ROM_CPU_LAST |=>
      fault[0] && !cmd[0].valid;
  endproperty
  a_rom_off: assert property (p_rom_off) else $error("rom unmap");
  property p_unmap_set;
    romUnmapSet |=> romUnmap ##1 ($stable(romUnmap) || $past(romUnmapClear));
  endproperty
  a_unmap_set: assert property (p_unmap_set) else $error("set");
  property p_spr_single;
    fresh[1] && fresh[4] && !busy[0] && busy[3:2] == 2'h0 &&
      req[1].addr inside {[SPR_CPU_BASE:SPR_CPU_LAST]} &&
      req[4].addr inside {[SPR_DMA_BASE:SPR_DMA_LAST]} &&
      req[1].addr[17:13] == req[4].addr[17:13] |=> s_loss;
  endproperty
  a_spr_single: assert property (p_spr_single) else $error("spr");
  property p_dpr_dual;
    fresh[0] && fresh[2] && !busy[1] &&
      req[0].addr inside {[MMR_BYTES:DPR_CPU_LAST]} &&
      req[2].addr inside {[MMR_BYTES:DPR_CPU_LAST]} |=>
      cmd[0].valid && cmd[2].valid;
  endproperty
  a_dpr_dual: assert property (p_dpr_dual) else $error("dual");
endmodule : omd_decoder_monitor

bind omd_decoder omd_decoder_monitor i_omd_decoder_monitor (
  .core_clk(core_clk), .reset_n(reset_n), .req(req),
  .romUnmapSet(romUnmapSet), .romUnmapClear(romUnmapClear), .cmd(cmd),
  .stall(stall), .fault(fault), .romUnmap(romUnmap));

// File: sim/omd_bus_model.sv
`timescale 1ns/100ps
module omd_bus_model (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  // flow control and request
  input  wire logic         stall,
  output omd_pkg::omd_req_t req
);
  import omd_pkg::*;
  omd_req_t pend [$];
  omd_req_t idle;
  // queue one request for the next free cycle
  task automatic push(input omd_req_t r);
    pend.push_back(r);
  endtask : push
  // hold while parked, else present next or release scrambled
  always @(posedge core_clk or negedge reset_n) begin
    #1;
    idle = ~req;
    idle.valid = 1'b0;
    if (!reset_n) req = '0;
    else if (!stall) req = (pend.size() > 0) ? pend.pop_front() : idle;
  end
  initial req = '0;
endmodule : omd_bus_model

// File: sim/onchip_memory_map_decoder_bench.sv
`timescale 1ns/100ps
module onchip_memory_map_decoder_bench;
  import omd_pkg::*;
  logic     core_clk = 1'b0;
  logic     reset_n = 1'b0;
  logic     romUnmapSet = 1'b0;
  logic     romUnmapClear = 1'b0;
  omd_req_t req [NUM_REQ];
  omd_cmd_t cmd [NUM_REQ];
  logic     stall [NUM_REQ];
  logic     fault [NUM_REQ];
  logic     romUnmap;
  int       bad_count = 0;
  int       n_checks = 0;
  // clock and parts
  always #10 core_clk = ~core_clk;
  for (genvar s = 0; s < NUM_REQ; s++) begin : g_bus
    omd_bus_model i_omd_bus_model (.core_clk(core_clk), .reset_n(reset_n),
      .stall(stall[s]), .req(req[s]));
  end
  omd_decoder i_omd_decoder (.core_clk(core_clk), .reset_n(reset_n),
    .req(req), .romUnmapSet(romUnmapSet), .romUnmapClear(romUnmapClear),
    .cmd(cmd), .stall(stall), .fault(fault), .romUnmap(romUnmap));
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic send(input int s, input logic [31:0] a, input logic w);
    omd_req_t r;
    r = '{valid: 1'b1, write: w, wide: (s == REQ_DMA), addr: a, wdata: ~a};
    case (s)
      0: g_bus[0].i_omd_bus_model.push(r);
      1: g_bus[1].i_omd_bus_model.push(r);
      2: g_bus[2].i_omd_bus_model.push(r);
      3: g_bus[3].i_omd_bus_model.push(r);
      default: g_bus[4].i_omd_bus_model.push(r);
    endcase
  endtask : send
  // one access, bounded wait for command or fault
  task automatic hit(input int s, input logic [31:0] a, input logic w,
                     input omd_region_t g, input int b, wd);
    int k;
    send(s, a, w);
    k = 0;
    while (cmd[s].valid !== 1'b1 && fault[s] !== 1'b1 && k < 8) begin
      @(negedge core_clk);
      k++;
    end
    if (k == 8) bad_count++;
    if (k == 8) final_report();
    check("region", (fault[s] === 1'b1) ? RGN_NONE : cmd[s].region, g);
    if (g inside {RGN_DPR, RGN_SPR, RGN_ROM}) begin
      check("block", cmd[s].block, b);
      check("word", cmd[s].word, wd);
      check("write", cmd[s].write, w);
      check("wide", cmd[s].wide, s == REQ_DMA);
      check("wdata", cmd[s].wdata, ~a);
    end
    @(negedge core_clk);
  endtask : hit
  task automatic ctl(input logic s, c, rst);
    @(posedge core_clk);
    #1 {romUnmapSet, romUnmapClear, reset_n} = {s, c, !rst};
    @(posedge core_clk);
    #1 {romUnmapSet, romUnmapClear, reset_n} = 3'h1;
    @(negedge core_clk);
  endtask : ctl
  task automatic t_dpr();
    for (int b = 0; b < 8; b++) begin
      hit(1, 32'h2000 * b + 32'h1ffe, 1'b0, RGN_DPR, b, 12'hfff);
      hit(3, 32'h12000 * 1 + 32'h2000 * b - 32'h1f40, 1'b1, RGN_DPR, b,
          12'h060);
    end
    hit(0, 32'h00be, 1'b0, RGN_MMR, 0, 0);
    hit(2, 32'h00c0, 1'b1, RGN_DPR, 0, 12'h060);
    $display("done dpr");
  endtask : t_dpr
  task automatic t_spr();
    for (int b = 0; b < 32; b++) begin
      hit(4, 32'h90002 + 32'h2000 * b, 1'b0, RGN_SPR, b, 1);
      hit(0, 32'h10000 + 32'h2000 * b, 1'b0, RGN_SPR, b, 0);
    end
    hit(1, 32'h50000, 1'b0, RGN_NONE, 0, 0);
    hit(4, 32'h10000, 1'b0, RGN_NONE, 0, 0);
    $display("done spr");
  endtask : t_spr
  task automatic t_rom();
    hit(0, 32'hfe0000, 1'b0, RGN_ROM, 0, 0);
    hit(1, 32'hfffffe, 1'b0, RGN_ROM, 3, 14'h3fff);
    hit(2, 32'hfe0000, 1'b1, RGN_NONE, 0, 0);
    hit(3, 32'hfe0000, 1'b0, RGN_NONE, 0, 0);
    ctl(1'b1, 1'b1, 1'b0);
    check("unmap", romUnmap, 1);
    hit(0, 32'hfe0000, 1'b0, RGN_NONE, 0, 0);
    ctl(1'b0, 1'b1, 1'b0);
    hit(0, 32'hfe0002, 1'b0, RGN_ROM, 0, 1);
    ctl(1'b1, 1'b0, 1'b0);
    ctl(1'b0, 1'b0, 1'b1);
    check("reset", romUnmap, 0);
    $display("done rom");
  endtask : t_rom
  task automatic t_clash();
    send(1, 32'h10002, 1'b0);
    send(4, 32'h90004, 1'b0);
    repeat (2) @(negedge core_clk);
    check("win", {cmd[1].valid, cmd[4].valid, stall[4]}, 3'h5);
    @(negedge core_clk);
    check("retry", {cmd[4].valid, stall[4]}, 2'h2);
    send(0, 32'h0100, 1'b0);
    send(2, 32'h0104, 1'b1);
    send(3, 32'h10108, 1'b0);
    send(3, 32'h1010c, 1'b1);
    repeat (2) @(negedge core_clk);
    check("dual", {cmd[0].valid, cmd[2].valid, cmd[3].valid}, 3'h6);
    @(negedge core_clk);
    check("dma1", {cmd[3].valid, cmd[3].word}, {1'b1, 14'h084});
    @(negedge core_clk);
    check("dma2", {cmd[3].valid, cmd[3].word}, {1'b1, 14'h086});
    @(negedge core_clk);
    $display("done clash");
  endtask : t_clash
  // main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    #1 reset_n = 1'b1;
    @(negedge core_clk);
    check("rst", {romUnmap, stall[4], cmd[0].valid}, 3'h0);
    t_dpr();
    t_spr();
    t_rom();
    t_clash();
    final_report();
  end
endmodule : onchip_memory_map_decoder_bench
